// ==== core/teau_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "teau_defs.svh"
module teau_top #(
    parameter int HOLD_W = 12
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic             wb_ack_o,
    input  wire logic        sec_tick_i,
    input  wire logic        timer_evt_i,
    input  wire logic        lux_valid_i,
    input  wire logic [7:0]  lux_pct_i,
    input  wire logic        loop_done_i,
    output logic             lamp_cmd_vld_o,
    output logic      [2:0]  lamp_cmd_o,
    output logic      [7:0]  lamp_level_o,
    output logic      [3:0]  lamp_scene_o,
    output logic      [15:0] colour_temperature_kelvin_o,
    output logic      [23:0] lamp_colour_o,
    output logic             relay_o,
    output logic             seq_start_o,
    output logic             seq_stop_o,
    output logic             seq_running_o
);
    // configuration words written by software
    logic [31:0] ctrl;    // sensor enable, lamp action, colour type, relay, seq opts
    logic [31:0] lamp;    // level, scene, colour temperature
    logic [31:0] relay;   // hold seconds
    logic [31:0] seq;     // loop count, rgb colour
    logic [7:0]  band_lo; // lower band edge, percent
    logic [7:0]  band_hi; // upper band edge, percent
    logic        wb_hit;  // request taken this cycle
    logic [HOLD_W-1:0] hold_cnt;  // seconds elapsed since relay switch
    logic        hold_act;        // restore pending
    logic        relay_prev;      // state to restore
    logic [7:0]  loops_left;      // remaining loops
    logic        stop_req;        // never set; a pending finish-cycle stop is held by TEAU_SQ_FINAL
    logic [7:0]  cur_level;       // level last commanded
    teau_pkg::teau_seq_state_t sq_state;
    teau_pkg::teau_lamp_act_t  lact;
    teau_pkg::teau_colour_t    ctype;
    logic        sens_en;
    logic [1:0]  rel_act;   // 0 disable, 1 on, 2 off, 3 toggle
    logic        restore_en;
    logic [1:0]  seq_act;   // 0 disable, 1 start, 2 stop
    logic        seq_endless;
    logic        stop_fin;
    logic        act_ok;
    logic [7:0]  lux_clip;

    // field decode of the control word
    assign sens_en     = ctrl[0];
    assign lact        = teau_pkg::teau_lamp_act_t'(ctrl[3:1]);
    assign ctype       = teau_pkg::teau_colour_t'(ctrl[6:4]);
    assign rel_act     = ctrl[9:8];
    assign restore_en  = ctrl[10];
    assign seq_act     = ctrl[13:12];
    assign seq_endless = ctrl[14];
    assign stop_fin    = ctrl[15];
    assign wb_hit      = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // readings above full scale are clipped to 100 percent
    assign lux_clip = (lux_pct_i > `TEAU_PCT_MAX) ? `TEAU_PCT_MAX : lux_pct_i;

    // action legality against the lamp colour type
    always_comb begin
        case (lact)
            teau_pkg::TEAU_LA_LEVEL:   act_ok = (ctype == teau_pkg::TEAU_CT_DIM);
            teau_pkg::TEAU_LA_LVL_TC:  act_ok = (ctype == teau_pkg::TEAU_CT_TC);
            teau_pkg::TEAU_LA_LVL_COL: act_ok = (ctype != teau_pkg::TEAU_CT_DIM);
            teau_pkg::TEAU_LA_OFF:     act_ok = 1'b1;
            teau_pkg::TEAU_LA_SCENE:   act_ok = 1'b1;
            default:                   act_ok = 1'b0;  // disable or unknown code
        endcase
    end

    // wishbone ack, one cycle, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_hit;
        end
    end

    // register writes with byte lanes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl    <= 32'h0000_0000;
            lamp    <= 32'h0000_0000;
            relay   <= 32'h0000_0000;
            seq     <= 32'h0000_0001;
            band_lo <= 8'h00;
            band_hi <= 8'h64;
        end else if (wb_hit && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    case (wb_adr_i)
                        `TEAU_ADR_CTRL:  ctrl[b*8 +: 8]  <= wb_dat_i[b*8 +: 8];
                        `TEAU_ADR_LAMP:  lamp[b*8 +: 8]  <= wb_dat_i[b*8 +: 8];
                        `TEAU_ADR_RELAY: relay[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
                        `TEAU_ADR_SEQ:   seq[b*8 +: 8]   <= wb_dat_i[b*8 +: 8];
                        default: ;
                    endcase
                end
            end
            if (wb_adr_i == `TEAU_ADR_SENSOR && wb_sel_i[0]) begin
                band_lo <= (wb_dat_i[7:0] > `TEAU_PCT_MAX) ? `TEAU_PCT_MAX : wb_dat_i[7:0];
            end
            if (wb_adr_i == `TEAU_ADR_SENSOR && wb_sel_i[1]) begin
                band_hi <= (wb_dat_i[15:8] > `TEAU_PCT_MAX) ? `TEAU_PCT_MAX : wb_dat_i[15:8];
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
                `TEAU_ADR_CTRL:   wb_dat_o <= ctrl;
                `TEAU_ADR_LAMP:   wb_dat_o <= lamp;
                `TEAU_ADR_RELAY:  wb_dat_o <= relay;
                `TEAU_ADR_SEQ:    wb_dat_o <= seq;
                `TEAU_ADR_SENSOR: wb_dat_o <= {16'h0000, band_hi, band_lo};
                // level and loops in the top bytes, state bits at the bottom
                `TEAU_ADR_STATUS: wb_dat_o <= {cur_level, loops_left, 11'h000,
                                                 sq_state, hold_act, relay_o};
                default:          wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // lamp command path: timer event first, then light sensor regulation
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lamp_cmd_vld_o              <= 1'b0;
            lamp_cmd_o                  <= 3'h0;
            lamp_level_o                <= 8'h00;
            lamp_scene_o                <= 4'h0;
            colour_temperature_kelvin_o <= 16'h0000;
            lamp_colour_o               <= 24'h000000;
            cur_level                   <= 8'h00;
        end else begin
            lamp_cmd_vld_o <= 1'b0;
            if (timer_evt_i && act_ok) begin
                lamp_cmd_vld_o <= 1'b1;
                lamp_cmd_o     <= 3'(lact);
                case (lact)
                    teau_pkg::TEAU_LA_OFF: begin
                        lamp_level_o <= 8'h00;
                        cur_level    <= 8'h00;
                    end
                    teau_pkg::TEAU_LA_SCENE: begin
                        // scene 1..16 held as 0..15 on the port
                        lamp_scene_o <= lamp[11:8];
                    end
                    default: begin
                        // level above 254 is clamped, 255 is a mask value on the bus
                        lamp_level_o <= (lamp[7:0] > `TEAU_LEVEL_MAX) ?
                                        `TEAU_LEVEL_MAX : lamp[7:0];
                        cur_level    <= (lamp[7:0] > `TEAU_LEVEL_MAX) ?
                                        `TEAU_LEVEL_MAX : lamp[7:0];
                        colour_temperature_kelvin_o <= lamp[31:16];
                        lamp_colour_o <= seq[31:8];
                    end
                endcase
            end else if (lux_valid_i && sens_en) begin
                if (lux_clip < band_lo && cur_level < `TEAU_LEVEL_MAX) begin
                    lamp_cmd_vld_o <= 1'b1;
                    lamp_cmd_o     <= teau_pkg::TEAU_LC_UP;
                    lamp_level_o   <= cur_level + `TEAU_LVL_STEP;
                    cur_level      <= cur_level + `TEAU_LVL_STEP;
                end else if (lux_clip > band_hi && cur_level != 8'h00) begin
                    lamp_cmd_vld_o <= 1'b1;
                    lamp_cmd_o     <= teau_pkg::TEAU_LC_DOWN;
                    lamp_level_o   <= cur_level - `TEAU_LVL_STEP;
                    cur_level      <= cur_level - `TEAU_LVL_STEP;
                end
            end
        end
    end

    // relay with optional timed restore
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            relay_o    <= 1'b0;
            relay_prev <= 1'b0;
            hold_act   <= 1'b0;
            hold_cnt   <= '0;
        end else if (timer_evt_i && rel_act != 2'h0) begin
            case (rel_act)
                2'h1:    relay_o <= 1'b1;
                2'h2:    relay_o <= 1'b0;
                default: relay_o <= !relay_o;
            endcase
            // a new event restarts the hold but keeps the original state
            if (!hold_act) begin
                relay_prev <= relay_o;
            end
            hold_act <= restore_en;
            hold_cnt <= '0;
        end else if (hold_act) begin
            if (hold_cnt >= relay[HOLD_W-1:0] || hold_cnt >= `TEAU_HOLD_MAX) begin
                relay_o  <= relay_prev;
                hold_act <= 1'b0;
            end else if (sec_tick_i) begin
                hold_cnt <= hold_cnt + 1'b1;
            end
        end
    end

    // sequence control; loop_done_i marks the end of one loop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq_state      <= teau_pkg::TEAU_SQ_IDLE;
            loops_left    <= 8'h00;
            stop_req      <= 1'b0;
            seq_start_o   <= 1'b0;
            seq_stop_o    <= 1'b0;
            seq_running_o <= 1'b0;
        end else begin
            seq_start_o <= 1'b0;
            seq_stop_o  <= 1'b0;
            case (sq_state)
                teau_pkg::TEAU_SQ_IDLE: begin
                    if (timer_evt_i && seq_act == 2'h1) begin
                        seq_start_o   <= 1'b1;
                        seq_running_o <= 1'b1;
                        loops_left    <= (seq[7:0] == 8'h00) ? 8'h01 : seq[7:0];
                        stop_req      <= 1'b0;
                        sq_state      <= teau_pkg::TEAU_SQ_RUN;
                    end
                end
                teau_pkg::TEAU_SQ_RUN: begin
                    if (timer_evt_i && seq_act == 2'h2 && !stop_fin) begin
                        seq_stop_o    <= 1'b1;
                        seq_running_o <= 1'b0;
                        sq_state      <= teau_pkg::TEAU_SQ_IDLE;
                    end else if (timer_evt_i && seq_act == 2'h2) begin
                        sq_state <= teau_pkg::TEAU_SQ_FINAL;
                    end else if (loop_done_i && !seq_endless) begin
                        if (loops_left == 8'h01) begin
                            seq_stop_o    <= 1'b1;
                            seq_running_o <= 1'b0;
                            sq_state      <= teau_pkg::TEAU_SQ_IDLE;
                        end
                        loops_left <= loops_left - 8'h01;
                    end
                end
                teau_pkg::TEAU_SQ_FINAL: begin
                    if (loop_done_i) begin
                        seq_stop_o    <= 1'b1;
                        seq_running_o <= 1'b0;
                        sq_state      <= teau_pkg::TEAU_SQ_IDLE;
                    end
                end
                default: sq_state <= teau_pkg::TEAU_SQ_IDLE;
            endcase
        end
    end
endmodule : teau_top
`default_nettype wire

// ==== core/teau_defs.svh ====
// Operation
// - inside band hold level, outside step it
// - sensor mode disabled ignores light readings
// - brightness reading is percent 0 to 100
// - timer off action switches lamps off
// - timer go-to-level sets level 0..254
// - timer go-to-scene recalls scene 1..16
// - action offered only for matching colour type
// - timer relay on/off action sets relay
// - timer relay toggle inverts relay state
// - timed restore returns relay after hold
// - without restore relay keeps new state
// - timer sequence start or stop action
// - sequence endless or 1..255 loops then halt
// - immediate stop ends sequence at once; ignored in TEAU_SQ_FINAL, which waits for loop end
// - finish-cycle stop halts at loop end
// - lamp action disabled sends no lamp command
`ifndef TEAU_DEFS_SVH
`define TEAU_DEFS_SVH
`define TEAU_ADR_CTRL     8'h00
`define TEAU_ADR_LAMP     8'h04
`define TEAU_ADR_RELAY    8'h08
`define TEAU_ADR_SEQ      8'h0C
`define TEAU_ADR_SENSOR   8'h10
`define TEAU_ADR_STATUS   8'h14
`define TEAU_PCT_MAX      8'h64
`define TEAU_LEVEL_MAX    8'hFE
`define TEAU_SCENE_MAX    5'h10
`define TEAU_HOLD_MAX     12'hE0F
`define TEAU_LVL_STEP     8'h01
`endif

// ==== core/teau_pkg.sv ====
package teau_pkg;
    // lamp action codes
    typedef enum logic [2:0] {
        TEAU_LA_DISABLE = 3'h0,
        TEAU_LA_OFF     = 3'h1,
        TEAU_LA_LEVEL   = 3'h2,
        TEAU_LA_SCENE   = 3'h3,
        TEAU_LA_LVL_TC  = 3'h4,
        TEAU_LA_LVL_COL = 3'h5
    } teau_lamp_act_t;
    // colour type of the associated lamps
    typedef enum logic [2:0] {
        TEAU_CT_DIM  = 3'h0,
        TEAU_CT_TC   = 3'h1,
        TEAU_CT_XY   = 3'h2,
        TEAU_CT_RGB  = 3'h3,
        TEAU_CT_RGBW = 3'h4
    } teau_colour_t;
    // lamp command codes placed on the lamp port
    typedef enum logic [2:0] {
        TEAU_LC_OFF     = 3'h1,
        TEAU_LC_LEVEL   = 3'h2,
        TEAU_LC_SCENE   = 3'h3,
        TEAU_LC_LVL_TC  = 3'h4,
        TEAU_LC_LVL_COL = 3'h5,
        TEAU_LC_UP      = 3'h6,
        TEAU_LC_DOWN    = 3'h7
    } teau_lamp_cmd_t;
    // sequence player state, one-hot
    typedef enum logic [2:0] {
        TEAU_SQ_IDLE  = 3'b001,
        TEAU_SQ_RUN   = 3'b010,
        TEAU_SQ_FINAL = 3'b100
    } teau_seq_state_t;
endpackage : teau_pkg

// ==== sim/teau_chk_sva.sv ====
`timescale 1ns/1ns
`default_nettype none
// port-level checker, single clock domain
module teau_chk #(
    parameter int HOLD_W = 12
) (
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic       sec_tick_i,
    input wire logic       timer_evt_i,
    input wire logic       lux_valid_i,
    input wire logic       loop_done_i,
    input wire logic       lamp_cmd_vld_o,
    input wire logic [2:0] lamp_cmd_o,
    input wire logic [7:0] lamp_level_o,
    input wire logic       relay_o,
    input wire logic       seq_start_o,
    input wire logic       seq_stop_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request not yet answered
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_after_req: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    // lamp commands only answer an event or a reading
    a_lamp_has_cause: assert property (lamp_cmd_vld_o |-> $past(timer_evt_i || lux_valid_i)
        || $past(timer_evt_i || lux_valid_i, 2)) else $error("lamp command uncaused");
    a_step_from_lux: assert property (lamp_cmd_vld_o && lamp_cmd_o >= 3'h6 |->
        $past(lux_valid_i) || $past(lux_valid_i, 2)) else $error("step without reading");
    a_level_in_range: assert property (lamp_cmd_vld_o |-> lamp_level_o <= 8'hFE)
        else $error("level above range");
    a_start_cause: assert property (seq_start_o |-> $past(timer_evt_i) || $past(timer_evt_i, 2))
        else $error("start uncaused");
    a_start_pulse: assert property (seq_start_o |=> !seq_start_o) else $error("start held");
    a_stop_cause: assert property (seq_stop_o |-> $past(timer_evt_i || loop_done_i)
        || $past(timer_evt_i || loop_done_i, 2)) else $error("stop uncaused");
    // relay may only move after an event or a seconds tick
    a_relay_cause: assert property ($changed(relay_o) |-> $past(timer_evt_i || sec_tick_i)
        || $past(timer_evt_i || sec_tick_i, 2) || $past(timer_evt_i || sec_tick_i, 3))
        else $error("relay moved alone");
endmodule : teau_chk
bind teau_top teau_chk #(.HOLD_W(HOLD_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sec_tick_i(sec_tick_i),
    .timer_evt_i(timer_evt_i), .lux_valid_i(lux_valid_i), .loop_done_i(loop_done_i),
    .lamp_cmd_vld_o(lamp_cmd_vld_o), .lamp_cmd_o(lamp_cmd_o), .lamp_level_o(lamp_level_o),
    .relay_o(relay_o), .seq_start_o(seq_start_o), .seq_stop_o(seq_stop_o));
`default_nettype wire

// ==== sim/teau_player.sv ====
`timescale 1ns/1ns
`default_nettype none
// sequence player: a loop lasts 16 cycles, long enough to outlast a bench scan window
module teau_player (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic start_i,
    input  wire logic stop_i,
    output logic      loop_done_o
);
    logic       busy; // playing a sequence
    logic [3:0] cnt;  // cycle within the loop
    // loop timer, restarted by every start
    always_ff @(posedge clk_i) begin
        loop_done_o <= busy && cnt == 4'hF;
        if (rst_i || stop_i) begin
            busy <= 1'b0;
            cnt  <= 4'h0;
        end else if (start_i) begin
            busy <= 1'b1;
            cnt  <= 4'h0;
        end else if (busy) begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : teau_player
`default_nettype wire

// ==== sim/timed_event_action_unit_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module timed_event_action_unit_tb;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, sec_tick_i, timer_evt_i, lux_valid_i;
    logic        wb_ack_o, lamp_cmd_vld_o, relay_o, seq_start_o, seq_stop_o, seq_running_o, ld;
    logic [7:0]  wb_adr_i, lux_pct_i, lamp_level_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i, lamp_scene_o;
    logic [2:0]  lamp_cmd_o, sc;
    logic [15:0] ctk;
    logic [23:0] lamp_colour_o;
    logic        sv, ss, sp, rl; // seen command, start, stop; relay level
    int          num_errors, n_checks, n, k;
    // table stimulus: control word and expected {seen, command}
    logic [31:0] lct[8] = '{32'h2, 32'h4, 32'h6, 32'h8, 32'h18, 32'hA, 32'h3A, 32'h0};
    logic [3:0]  lex[8] = '{4'h9, 4'hA, 4'hB, 4'h0, 4'hC, 4'h0, 4'hD, 4'h0};
    // level starts at 254: step down first so that a step up is possible
    logic [7:0]  lux[6] = '{8'h50, 8'h14, 8'h1E, 8'h32, 8'h05, 8'hC8};
    logic [3:0]  uex[6] = '{4'hF, 4'h0, 4'h0, 4'h0, 4'hE, 4'hF};
    teau_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sec_tick_i(sec_tick_i),
        .timer_evt_i(timer_evt_i), .lux_valid_i(lux_valid_i), .lux_pct_i(lux_pct_i),
        .loop_done_i(ld), .lamp_cmd_vld_o(lamp_cmd_vld_o), .lamp_cmd_o(lamp_cmd_o),
        .lamp_level_o(lamp_level_o), .lamp_scene_o(lamp_scene_o),
        .colour_temperature_kelvin_o(ctk), .lamp_colour_o(lamp_colour_o), .relay_o(relay_o),
        .seq_start_o(seq_start_o), .seq_stop_o(seq_stop_o), .seq_running_o(seq_running_o));
    teau_player u_player (.clk_i(clk_i), .rst_i(rst_i), .start_i(seq_start_o),
        .stop_i(seq_stop_o), .loop_done_o(ld));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check
    // one classic cycle; held until ack is sampled, then idle for a cycle
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int w;
        w = 0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
        do begin
            @(posedge clk_i);
            w++;
        end while (wb_ack_o !== 1'b1 && w < 20);
        rd = wb_dat_o;
        if (w >= 20) check(0, 1, "no ack");
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask : wb
    // one-cycle pulse {tick, reading, event}, then watch the outputs for four cycles
    task automatic pulse(input logic [2:0] p, input logic [7:0] v);
        {sec_tick_i, lux_valid_i, timer_evt_i, lux_pct_i} <= {p, v};
        @(posedge clk_i);
        {sec_tick_i, lux_valid_i, timer_evt_i} <= 3'h0;
        {sv, sc, ss, sp} = 6'h00;
        repeat (4) begin
            #1;
            if (lamp_cmd_vld_o === 1'b1) {sv, sc} = {1'b1, lamp_cmd_o};
            if (seq_start_o === 1'b1) ss = 1'b1;
            if (seq_stop_o === 1'b1) sp = 1'b1;
            rl = relay_o;
            @(posedge clk_i);
        end
    endtask : pulse
    initial begin
        #(100 * 5000);
        num_errors++;
        complete_run();
    end
    initial begin
        {rst_i, wb_we_i, wb_cyc_i, wb_stb_i, sec_tick_i, timer_evt_i, lux_valid_i} = 7'h40;
        {wb_adr_i, lux_pct_i, wb_dat_i, wb_sel_i} = {48'h0, 4'hF};
        num_errors = 0;
        n_checks = 0;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, 8'h0C, 0); check(rd, 32'h1, "loop count reset");
        wb(0, 8'h10, 0); check(rd[15:0], 16'h6400, "band reset");
        wb(0, 8'h18, 0); check(rd, 0, "unmapped read");
        // timer lamp actions over all codes, colour types dim, tc and rgb only
        wb(1, 8'h04, 32'h0ABC_0FFE);
        for (k = 0; k < 8; k++) begin
            wb(1, 8'h00, lct[k]); pulse(3'h1, 0);
            check({sv, sc}, lex[k], "lamp action");
        end
        check(lamp_level_o, 8'hFE, "level");
        check(lamp_scene_o, 4'hF, "scene 16");
        check(ctk, 16'h0ABC, "colour temperature");
        // light band 20..50 percent, readings at and beyond both edges
        wb(1, 8'h10, 32'h3214); pulse(3'h2, 8'h05); check(sv, 0, "sensor off");
        wb(1, 8'h00, 32'h1);
        for (k = 0; k < 6; k++) begin
            pulse(3'h2, lux[k]); check({sv, sc}, uex[k], "band step");
        end
        // relay on, toggle twice, off, then on and untouched by ticks
        wb(1, 8'h00, 32'h100); pulse(3'h1, 0); check(rl, 1, "relay on");
        wb(1, 8'h00, 32'h300); pulse(3'h1, 0); check(rl, 0, "toggle");
        pulse(3'h1, 0); check(rl, 1, "toggle back");
        wb(1, 8'h00, 32'h200); pulse(3'h1, 0); check(rl, 0, "relay off");
        wb(1, 8'h00, 32'h100); pulse(3'h1, 0);
        repeat (3) pulse(3'h4, 0);
        check(rl, 1, "relay kept");
        // timed restore with a two second hold
        wb(1, 8'h08, 32'h2); wb(1, 8'h00, 32'h200); pulse(3'h1, 0);
        wb(1, 8'h00, 32'h500); pulse(3'h1, 0); check(rl, 1, "restore on");
        pulse(3'h4, 0); check(rl, 1, "hold one second");
        pulse(3'h4, 0); check(rl, 0, "restored");
        // two counted loops, then halt
        wb(1, 8'h00, 0); wb(1, 8'h0C, 32'h2); wb(1, 8'h00, 32'h1000);
        pulse(3'h1, 0); check(ss, 1, "start");
        n = 0;
        k = 0;
        while (seq_stop_o !== 1'b1 && n < 80) begin
            @(posedge clk_i);
            k += int'(ld === 1'b1);
            n++;
        end
        check(k, 2, "loops before halt");
        // immediate stop, then finish-cycle stop
        wb(1, 8'h00, 32'h5000); pulse(3'h1, 0);
        wb(1, 8'h00, 32'h6000); pulse(3'h1, 0); check(sp, 1, "stop now");
        wb(1, 8'h00, 32'h5000); pulse(3'h1, 0); check(ss, 1, "endless start");
        check(seq_running_o, 1, "running");
        wb(1, 8'h00, 32'hE000); pulse(3'h1, 0); check(sp, 0, "stop deferred");
        n = 0;
        while (seq_stop_o !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        check(n < 40, 1, "stop at loop end");
        check(seq_running_o, 0, "halted");
        complete_run();
    end
endmodule : timed_event_action_unit_tb
`default_nettype wire
